// >>> tlbmo_pkg.sv
// package: register map, field layout, entry type and operation codes for tlb maintenance
package tlbmo_pkg;

  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] OFS_ENTRY_UPPER = 8'h00;
  localparam logic [7:0] OFS_LOWER_EVEN  = 8'h04;
  localparam logic [7:0] OFS_LOWER_ODD   = 8'h08;
  localparam logic [7:0] OFS_PAGE_MASK   = 8'h0C;
  localparam logic [7:0] OFS_INDEX       = 8'h10;
  localparam logic [7:0] OFS_CONFIG      = 8'h14;
  localparam logic [7:0] OFS_CONFIG_FOUR = 8'h18;
  localparam logic [7:0] OFS_COMMAND     = 8'h1C;
  localparam logic [7:0] OFS_STATUS      = 8'h20;

  // widths of the stored entry fields
  localparam int VPN_W  = 19;
  localparam int TAG_W  = 8;
  localparam int MASK_W = 16;
  localparam int PFN_W  = 24;

  // field positions inside the staging registers
  localparam int ENTRY_INVALID_POS = 10;
  localparam int VPN_LSB           = 13;
  localparam int MASK_LSB          = 13;
  localparam int PFN_LSB           = 6;
  localparam int MISS_POS          = 31;

  // field positions inside the config register
  localparam int CFG_MT_LSB  = 0;
  localparam int CFG_IE_LSB  = 4;
  localparam int CFG_CU0_POS = 8;
  localparam int CFG_REV_LSB = 12;

  // field positions inside config_four_reg
  localparam int C4_BASE_LSB = 0;
  localparam int C4_LEG_LSB  = 8;
  localparam int C4_VAR_LSB  = 16;
  localparam int C4_SEL_LSB  = 20;
  localparam int C4_WAYS_LSB = 24;
  localparam int C4_SETS_LSB = 28;

  // status bit positions
  localparam int ST_CPU_POS  = 0;
  localparam int ST_RI_POS   = 1;
  localparam int ST_MCHK_POS = 2;

  // mmu type codes, invalidate capability codes and size extension selector codes
  localparam logic [2:0] MT_JOINT     = 3'h1;
  localparam logic [2:0] MT_BLOCK     = 3'h2;
  localparam logic [2:0] MT_FIXED_MAP = 3'h3;
  localparam logic [2:0] MT_VAR_FIX   = 3'h4;
  localparam logic [1:0] IE_SW_WALK   = 2'h2;
  localparam logic [1:0] IE_HW_WALK   = 2'h3;
  localparam logic [1:0] SEL_VAR      = 2'h3;
  localparam logic [1:0] SEL_LEGACY   = 2'h1;
  localparam logic [3:0] REV_SIX      = 4'h6;
  localparam int         EXT_SHIFT    = 6;
  localparam int         WAY_BIAS     = 2;

  // reset values
  localparam logic [31:0] RST_CONFIG      = 32'h0000_6114;
  localparam logic [31:0] RST_CONFIG_FOUR = 32'h0100_000B;

  // maintenance operation codes written to the command register
  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_FLUSH = 3'b001,
    OP_PROBE = 3'b010,
    OP_READ  = 3'b011,
    OP_WRITE = 3'b100
  } tlbmo_op_e;

  // one stored translation entry
  typedef struct packed {
    logic              page_invalid_flag;
    logic              glob;
    logic [MASK_W-1:0] mask;
    logic [VPN_W-1:0]  virtual_page_pair_number;
    logic [TAG_W-1:0]  tag;
    logic [PFN_W-1:0]  pfn0;
    logic [2:0]        c0;
    logic              d0;
    logic              v0;
    logic [PFN_W-1:0]  pfn1;
    logic [2:0]        c1;
    logic              d1;
    logic              v1;
  } tlbmo_entry_s;

endpackage : tlbmo_pkg

// >>> tlbmo_top.sv
// tlb maintenance block: flush, probe, indexed read and indexed write behind an ahb-lite slave
// How it works
// - joint array, or software walk with index in variable array: flush whole variable array
// - software walk, index past variable array: flush only the selected fixed-array set
// - hardware walk: flush both arrays in one go, index ignored
// - flush sets the invalid flag in range, ignoring tags and global bits
// - variable array count is one plus base size ORed with shifted extension
// - fixed array count is (ways plus two) times two to the set code, type four only
// - probe compares entry_upper_reg against entries and loads index with the match
// - probe miss sets the top bit of the index register
// - multiple matches reported as machine check on writes only
// - every operation raises coprocessor-unusable when coprocessor zero access is off
// - block-translation or fixed-mapping mmu types raise reserved_op_exception
// - read loads upper, both lower and page mask registers from indexed entry
// - reading an invalid entry gives zeros, invalid bit set, minimum page mask
// - valid read upper register: page pair number, five zeros, address space tag
// - read copies the single global bit into both lower registers
// - masked bits of page and frame numbers are zeroed on write, always
// - write without invalidation or overlap stores staging registers into the indexed entry
// - stored global bit is the AND of both lower global bits
// - write detects multiple matches and signals machine check
// - invalidating write only flags the entry invalid, no machine check
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
module tlbmo_top
  import tlbmo_pkg::*;
#(
  parameter int ENTRIES = 16
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        CE_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic             EXC_CPU_O,
  output logic             EXC_RI_O,
  output logic             EXC_MCHK_O
);
  import tlbmo_pkg::*;

  // one select bit even for one entry
  localparam int IDX_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

  // whole module state in one record
  typedef struct packed {
    tlbmo_entry_s [ENTRIES-1:0] tlb;
    logic [31:0]                entry_upper_reg;
    logic [31:0]                entry_lower_even_reg;
    logic [31:0]                entry_lower_odd_reg;
    logic [31:0]                page_mask_reg;
    logic [31:0]                index_reg;
    logic [31:0]                config_reg;
    logic [31:0]                config_four_reg;
    logic [31:0]                status_reg;
    logic                       wr_pend;
    logic [7:0]                 wr_addr;
    logic [31:0]                hrdata;
    logic                       exc_cpu;
    logic                       exc_ri;
    logic                       exc_mchk;
  } tlbmo_state_s;

  // registered state and its next value
  tlbmo_state_s state_ff;
  tlbmo_state_s nxt_state;

  // match of an entry against a page pair number and tag, honouring its own mask
  function automatic logic entry_hit(input tlbmo_entry_s e, input logic [VPN_W-1:0] vpn,
                                     input logic [TAG_W-1:0] tag);
    logic [VPN_W-1:0] care;
    care = ~{{(VPN_W-MASK_W){1'b0}}, e.mask};
    entry_hit = !e.page_invalid_flag && (((e.virtual_page_pair_number ^ vpn) & care) == '0)
                && (e.glob || (e.tag == tag));
  endfunction : entry_hit

  // read data and exception outputs come straight from the state record
  assign HRDATA_O    = state_ff.hrdata;
  // zero wait states, always okay
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign EXC_CPU_O   = state_ff.exc_cpu;
  assign EXC_RI_O    = state_ff.exc_ri;
  assign EXC_MCHK_O  = state_ff.exc_mchk;

  // next-state logic: bus slave, staging registers and the four maintenance operations
  always_comb
  begin
    tlbmo_op_e         op;
    logic [2:0]        mt;
    logic [1:0]        ie;
    logic [3:0]        ext;
    logic [IDX_W-1:0]  idx;
    int                vsize;
    int                fsize;
    int                set_sz;
    int                first;
    int                last;
    int                hit_pos;
    logic              hit;
    logic              multi;
    logic              addr_phase;
    tlbmo_entry_s      e;
    tlbmo_entry_s      ne;
    logic [31:0]       rd;
    logic [VPN_W-1:0]  wmask;
    logic [PFN_W-1:0]  pmask;
    // hold all by default
    nxt_state = state_ff;
    op        = OP_NONE;
    mt        = state_ff.config_reg[CFG_MT_LSB +: 3];
    ie        = state_ff.config_reg[CFG_IE_LSB +: 2];
    ext       = 4'h0;
    idx       = state_ff.index_reg[IDX_W-1:0];
    vsize     = 0;
    fsize     = 0;
    set_sz    = 0;
    first     = 0;
    last      = -1;
    hit_pos   = 0;
    hit       = 1'b0;
    multi     = 1'b0;
    // size is not decoded: words only
    addr_phase = HSEL_I && HTRANS_I[1] && HREADY_I;
    e         = state_ff.tlb[idx];
    ne        = '0;
    rd        = 32'h0000_0000;
    wmask     = '0;
    pmask     = '0;
    // exception outputs are one-cycle pulses
    nxt_state.exc_cpu  = 1'b0;
    nxt_state.exc_ri   = 1'b0;
    nxt_state.exc_mchk = 1'b0;

    // sizes follow config live
    // size extension source picked by release and selector
    if ((state_ff.config_reg[CFG_REV_LSB +: 4] >= REV_SIX)
        || (state_ff.config_four_reg[C4_SEL_LSB +: 2] == SEL_VAR))
    begin
      ext = state_ff.config_four_reg[C4_VAR_LSB +: 4];
    end
    else if (state_ff.config_four_reg[C4_SEL_LSB +: 2] == SEL_LEGACY)
    begin
      ext = state_ff.config_four_reg[C4_LEG_LSB +: 4];
    end
    vsize = 1 + ((int'(ext) << EXT_SHIFT) | int'(state_ff.config_four_reg[C4_BASE_LSB +: 6]));
    set_sz = int'(state_ff.config_four_reg[C4_WAYS_LSB +: 3]) + WAY_BIAS;
    if (mt == MT_VAR_FIX)
    begin
      fsize = set_sz * (1 << state_ff.config_four_reg[C4_SETS_LSB +: 4]);
    end

    // data phase of a write: commit to the addressed register
    if (state_ff.wr_pend)
    begin
      case (state_ff.wr_addr)
        OFS_ENTRY_UPPER: nxt_state.entry_upper_reg      = HWDATA_I;
        OFS_LOWER_EVEN:  nxt_state.entry_lower_even_reg = HWDATA_I;
        OFS_LOWER_ODD:   nxt_state.entry_lower_odd_reg  = HWDATA_I;
        OFS_PAGE_MASK:   nxt_state.page_mask_reg        = HWDATA_I;
        OFS_INDEX:       nxt_state.index_reg            = HWDATA_I;
        OFS_CONFIG:      nxt_state.config_reg           = HWDATA_I;
        OFS_CONFIG_FOUR: nxt_state.config_four_reg      = HWDATA_I;
        OFS_COMMAND:     op = tlbmo_op_e'(HWDATA_I[2:0]);
        default:         op = OP_NONE;
      endcase
    end

    // exception checks come before any effect on the array
    // cpu access outranks mmu type
    if (op != OP_NONE)
    begin
      nxt_state.status_reg = 32'h0000_0000;
      if (!state_ff.config_reg[CFG_CU0_POS])
      begin
        nxt_state.exc_cpu = 1'b1;
        nxt_state.status_reg[ST_CPU_POS] = 1'b1;
        op = OP_NONE;
      end
      else if ((mt == MT_BLOCK) || (mt == MT_FIXED_MAP))
      begin
        nxt_state.exc_ri = 1'b1;
        nxt_state.status_reg[ST_RI_POS] = 1'b1;
        op = OP_NONE;
      end
    end

    case (op)
      OP_FLUSH:
      begin
        // pick the covered range, then flag every entry in it
        if ((mt == MT_JOINT) || ((mt == MT_VAR_FIX) && (ie == IE_SW_WALK)
            && (int'(state_ff.index_reg) < vsize)))
        begin
          first = 0;
          last  = vsize - 1;
        end
        else if ((mt == MT_VAR_FIX) && (ie == IE_SW_WALK))
        begin
          // fixed sets sit back to back after the variable array, set_sz entries each
          first = vsize;
          for (int k = 0; k < ENTRIES; k++)
          begin
            if (int'(state_ff.index_reg) >= first + set_sz)
            begin
              first = first + set_sz;
            end
          end
          last = first + set_sz - 1;
        end
        else if ((mt == MT_VAR_FIX) && (ie == IE_HW_WALK))
        begin
          first = 0;
          last  = vsize + fsize - 1;
        end
        for (int i = 0; i < ENTRIES; i++)
        begin
          if ((i >= first) && (i <= last))
          begin
            nxt_state.tlb[i].page_invalid_flag = 1'b1;
          end
        end
      end
      OP_PROBE:
      begin
        // lowest matching position wins; multiple hits are left for writes to report
        for (int i = ENTRIES - 1; i >= 0; i--)
        begin
          if (entry_hit(state_ff.tlb[i],
                        state_ff.entry_upper_reg[VPN_LSB +: VPN_W],
                        state_ff.entry_upper_reg[TAG_W-1:0]))
          begin
            hit     = 1'b1;
            hit_pos = i;
          end
        end
        // a miss keeps the old index bits
        if (hit)
        begin
          nxt_state.index_reg = 32'(hit_pos);
        end
        else
        begin
          nxt_state.index_reg[MISS_POS] = 1'b1;
        end
      end
      OP_READ:
      begin
        // invalid entries read as empty
        if ((ie != 2'h0) && e.page_invalid_flag)
        begin
          nxt_state.entry_upper_reg      = 32'h0000_0000;
          nxt_state.entry_upper_reg[ENTRY_INVALID_POS] = 1'b1;
          nxt_state.entry_lower_even_reg = 32'h0000_0000;
          nxt_state.entry_lower_odd_reg  = 32'h0000_0000;
          nxt_state.page_mask_reg        = 32'h0000_0000;
        end
        else
        begin
          // masked bits were already zeroed on the way in, so no masking here
          nxt_state.entry_upper_reg      = {e.virtual_page_pair_number, 5'h00, e.tag};
          nxt_state.entry_lower_even_reg = {2'h0, e.pfn0, e.c0, e.d0, e.v0, e.glob};
          nxt_state.entry_lower_odd_reg  = {2'h0, e.pfn1, e.c1, e.d1, e.v1, e.glob};
          nxt_state.page_mask_reg        = 32'h0000_0000;
          nxt_state.page_mask_reg[MASK_LSB +: MASK_W] = e.mask;
        end
      end
      OP_WRITE:
      begin
        // index assumed below ENTRIES; higher bits are simply dropped
        if ((ie != 2'h0) && state_ff.entry_upper_reg[ENTRY_INVALID_POS])
        begin
          nxt_state.tlb[idx].page_invalid_flag = 1'b1;
        end
        else
        begin
          ne.mask  = state_ff.page_mask_reg[MASK_LSB +: MASK_W];
          wmask    = ~{{(VPN_W-MASK_W){1'b0}}, ne.mask};
          pmask    = ~{{(PFN_W-MASK_W){1'b0}}, ne.mask};
          ne.virtual_page_pair_number  = state_ff.entry_upper_reg[VPN_LSB +: VPN_W] & wmask;
          ne.tag   = state_ff.entry_upper_reg[TAG_W-1:0];
          ne.glob  = state_ff.entry_lower_even_reg[0] & state_ff.entry_lower_odd_reg[0];
          ne.pfn0  = state_ff.entry_lower_even_reg[PFN_LSB +: PFN_W] & pmask;
          ne.c0    = state_ff.entry_lower_even_reg[5:3];
          ne.d0    = state_ff.entry_lower_even_reg[2];
          ne.v0    = state_ff.entry_lower_even_reg[1];
          ne.pfn1  = state_ff.entry_lower_odd_reg[PFN_LSB +: PFN_W] & pmask;
          ne.c1    = state_ff.entry_lower_odd_reg[5:3];
          ne.d1    = state_ff.entry_lower_odd_reg[2];
          ne.v1    = state_ff.entry_lower_odd_reg[1];
          ne.page_invalid_flag = 1'b0;
          // an overlap with any other live entry would leave two matches behind
          for (int j = 0; j < ENTRIES; j++)
          begin
            if ((j != int'(idx)) && !state_ff.tlb[j].page_invalid_flag
                && (((state_ff.tlb[j].virtual_page_pair_number ^ ne.virtual_page_pair_number)
                     & ~{{(VPN_W-MASK_W){1'b0}}, (state_ff.tlb[j].mask | ne.mask)}) == '0)
                && (state_ff.tlb[j].glob || ne.glob || (state_ff.tlb[j].tag == ne.tag)))
            begin
              multi = 1'b1;
            end
          end
          // overlapping writes are dropped
          if (multi)
          begin
            nxt_state.exc_mchk = 1'b1;
            nxt_state.status_reg[ST_MCHK_POS] = 1'b1;
          end
          else
          begin
            nxt_state.tlb[idx] = ne;
          end
        end
      end
      default:
      begin
        nxt_state.status_reg = nxt_state.status_reg;
      end
    endcase

    // reads see state before the edge
    // address phase: latch writes, fetch read data so it stands in the data phase
    nxt_state.wr_pend = addr_phase && HWRITE_I;
    if (addr_phase)
    begin
      nxt_state.wr_addr = HADDR_I[7:0];
      if (HADDR_I[31:8] == 24'h00_0000)
      begin
        case (HADDR_I[7:0])
          OFS_ENTRY_UPPER: rd = state_ff.entry_upper_reg;
          OFS_LOWER_EVEN:  rd = state_ff.entry_lower_even_reg;
          OFS_LOWER_ODD:   rd = state_ff.entry_lower_odd_reg;
          OFS_PAGE_MASK:   rd = state_ff.page_mask_reg;
          OFS_INDEX:       rd = state_ff.index_reg;
          OFS_CONFIG:      rd = state_ff.config_reg;
          OFS_CONFIG_FOUR: rd = state_ff.config_four_reg;
          OFS_STATUS:      rd = state_ff.status_reg;
          default:         rd = 32'h0000_0000;
        endcase
      end
      else
      begin
        // out-of-window addresses stay writable-nowhere
        nxt_state.wr_addr = 8'hFF;
      end
      nxt_state.hrdata = rd;
    end
  end

  // reset beats the enable
  // single register stage; clock enable freezes everything
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      state_ff                 <= '0;
      state_ff.config_reg      <= RST_CONFIG;
      state_ff.config_four_reg <= RST_CONFIG_FOUR;
    end
    else if (CE_I)
    begin
      state_ff <= nxt_state;
    end
  end

endmodule : tlbmo_top

// >>> tlbmo_ahb_master.sv
// ahb-lite master model standing in for the pipeline that issues maintenance ops
module tlbmo_ahb_master
(
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [2:0]       hsize_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [31:0]      hwdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial
  begin
    hsel_o = 1'b1;
    haddr_o = 32'h0;
    hsize_o = 3'h2;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0;
  end

  // single word write; stale write data is inverted so it never looks valid
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    haddr_o <= a;
    hwrite_o <= 1'b1;
    htrans_o <= 2'h2;
    hwdata_o <= ~hwdata_o;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    hwdata_o <= v;
    do @(posedge clk_i); while (hready_i !== 1'b1);
  endtask : wr

  // single word read, data taken at the edge that ends the data phase
  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    haddr_o <= a;
    hwrite_o <= 1'b0;
    htrans_o <= 2'h2;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    v = hrdata_i;
  endtask : rd
endmodule : tlbmo_ahb_master

// >>> tlbmo_asserts.sv
// port-level checks of the tlb maintenance block
module tlbmo_asserts
  import tlbmo_pkg::*;
(
  input wire logic        CORE_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        CE_I,
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  input wire logic        EXC_CPU_O,
  input wire logic        EXC_RI_O,
  input wire logic        EXC_MCHK_O
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        wr_cmd_ff;
  logic        rd_cmd_ff;
  logic        wr_cfg_ff;
  logic [2:0]  op_ff;
  logic [31:0] cfg_ff;
  logic        take;
  logic        any_exc;
  logic        cu_on;
  logic        bad_mt;

  // decode of the current bus request and of the shadowed config
  assign take    = HSEL_I & HTRANS_I[1] & HREADY_I & CE_I;
  assign any_exc = EXC_CPU_O | EXC_RI_O | EXC_MCHK_O;
  assign cu_on   = cfg_ff[CFG_CU0_POS];
  assign bad_mt  = (cfg_ff[2:0] == MT_BLOCK) || (cfg_ff[2:0] == MT_FIXED_MAP);

  // shadow config so checks know the mode an op was issued under
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RSTN_I)
    begin
      wr_cmd_ff <= 1'b0;
      rd_cmd_ff <= 1'b0;
      wr_cfg_ff <= 1'b0;
      op_ff <= 3'h0;
      cfg_ff <= RST_CONFIG;
    end
    else if (CE_I)
    begin
      wr_cmd_ff <= take & HWRITE_I & (HADDR_I == {24'h0, OFS_COMMAND});
      rd_cmd_ff <= take & !HWRITE_I & (HADDR_I == {24'h0, OFS_COMMAND});
      wr_cfg_ff <= take & HWRITE_I & (HADDR_I == {24'h0, OFS_CONFIG});
      if (wr_cmd_ff) op_ff <= HWDATA_I[2:0];
      if (wr_cfg_ff) cfg_ff <= HWDATA_I;
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_op_issue;
    wr_cmd_ff && (HWDATA_I[2:0] inside {[3'h1:3'h4]});
  endsequence
  sequence s_op_legal;
    s_op_issue ##0 (cu_on && !bad_mt);
  endsequence

  chk_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
    else $error("slave not ready or not okay");
  chk_cpu_refused: assert property (s_op_issue ##0 !cu_on |=> EXC_CPU_O && !EXC_RI_O)
    else $error("coprocessor unusable not raised");
  chk_ri_refused: assert property (s_op_issue ##0 cu_on && bad_mt |=> EXC_RI_O && !EXC_CPU_O)
    else $error("reserved op not raised");
  chk_legal_runs: assert property (s_op_legal |=> !EXC_CPU_O && !EXC_RI_O)
    else $error("legal op refused");
  chk_exc_cause: assert property (any_exc |-> $past(wr_cmd_ff))
    else $error("exception without an op");
  chk_exc_single: assert property (any_exc |=> !any_exc)
    else $error("exception longer than one cycle");
  chk_mchk_write: assert property (EXC_MCHK_O |-> op_ff == OP_WRITE)
    else $error("machine check not from a write");
  chk_probe_quiet: assert property (s_op_legal ##0 HWDATA_I[2:0] != OP_WRITE |=> !EXC_MCHK_O)
    else $error("machine check on a non-write op");
  chk_nop_quiet: assert property (wr_cmd_ff && !(HWDATA_I[2:0] inside {[3'h1:3'h4]}) |=> !any_exc)
    else $error("exception on a no-op command");
  chk_cmd_zero: assert property (rd_cmd_ff |-> HRDATA_O == 32'h0)
    else $error("command register read not zero");
endmodule : tlbmo_asserts

bind tlbmo_top tlbmo_asserts u_tlbmo_asserts (
  .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I), .HSEL_I(HSEL_I),
  .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I),
  .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .EXC_CPU_O(EXC_CPU_O), .EXC_RI_O(EXC_RI_O), .EXC_MCHK_O(EXC_MCHK_O));

// >>> tlbmo_tb_top.sv
// self-checking bench for the tlb maintenance block
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tlbmo_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tlbmo_pkg::*;
  logic        clk;
  logic        rstn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [31:0] d;
  int          errors;
  int          checked;
  int          cycles;
  // flush cases: entry positions, config, config_four, index, positions used, invalid map
  logic [3:0]  pos [6] = '{4'd0, 4'd3, 4'd4, 4'd6, 4'd7, 4'd14};
  logic [31:0] fcfg [8] = '{32'h6124, 32'h6124, 32'h6134, 32'h6124, 32'h6124, 32'h6121,
                            32'h5124, 32'h5124};
  logic [31:0] fc4 [8] = '{RST_CONFIG_FOUR, RST_CONFIG_FOUR, RST_CONFIG_FOUR,
                           32'h0100_0003, 32'h0100_0003, 32'h0100_0003,
                           32'h0110_010B, 32'h0101_000B};
  logic [3:0]  fidx [8] = '{4'd0, 4'd12, 4'd3, 4'd0, 4'd4, 4'd2, 4'd12, 4'd12};
  int          fn [8] = '{6, 6, 6, 4, 4, 2, 6, 6};
  logic [5:0]  fexp [8] = '{6'h1F, 6'h20, 6'h3F, 6'h03, 6'h0C, 6'h03, 6'h3F, 6'h20};
  // refusal cases: cu0 off, type 2, type 3, both; hardware walk so a leak would show
  logic [31:0] rcfg [4] = '{32'h6034, 32'h6132, 32'h6133, 32'h6032};
  logic [31:0] rexp [4] = '{32'h1, 32'h2, 32'h2, 32'h1};

  always #2 clk = ~clk;

  tlbmo_top #(.ENTRIES(16)) u_tlbmo_top (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(),
    .EXC_CPU_O(), .EXC_RI_O(), .EXC_MCHK_O());

  tlbmo_ahb_master u_tlbmo_ahb_master (
    .clk_i(clk), .hready_i(hreadyout), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata),
    .hsize_o(hsize));

  task automatic w(input logic [7:0] a, input logic [31:0] v);
    u_tlbmo_ahb_master.wr({24'h0, a}, v);
  endtask : w
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
    u_tlbmo_ahb_master.rd({24'h0, a}, d);
    `CHK(d, e)
  endtask : expect_reg
  task automatic op(input tlbmo_op_e o);
    w(OFS_COMMAND, {29'h0, o});
  endtask : op
  function automatic logic [31:0] lower(input logic [23:0] physical_frame_number, input logic g);
    return {2'h0, physical_frame_number, 3'h3, 2'h3, g};
  endfunction : lower
  // stage an entry and store it at position i
  task automatic put(input logic [3:0] i, input logic [18:0] vpn, input logic ge,
                     input logic go, input logic [15:0] m);
    w(OFS_INDEX, {28'h0, i});
    w(OFS_ENTRY_UPPER, {vpn, 5'h0, 8'h5A});
    w(OFS_LOWER_EVEN, lower({5'h0, vpn}, ge));
    w(OFS_LOWER_ODD, lower({5'h0, vpn}, go));
    w(OFS_PAGE_MASK, {3'h0, m, 13'h0});
    op(OP_WRITE);
  endtask : put
  // upper and both lower staging registers are cleared first so a read that loads nothing is caught
  task automatic readback(input logic [3:0] i, input logic [18:0] vpn, input logic g,
                          input logic [15:0] m);
    logic [18:0] ev;
    logic [23:0] ep;
    ev = vpn & ~{3'h0, m};
    ep = {5'h0, vpn} & ~{8'h0, m};
    w(OFS_INDEX, {28'h0, i});
    w(OFS_ENTRY_UPPER, 32'h0);
    w(OFS_LOWER_EVEN, 32'h0);
    w(OFS_LOWER_ODD, 32'h0);
    op(OP_READ);
    expect_reg(OFS_ENTRY_UPPER, {ev, 5'h0, 8'h5A});
    expect_reg(OFS_LOWER_EVEN, lower(ep, g));
    expect_reg(OFS_LOWER_ODD, lower(ep, g));
    expect_reg(OFS_PAGE_MASK, {3'h0, m, 13'h0});
  endtask : readback
  task automatic look(input logic [3:0] i);
    w(OFS_INDEX, {28'h0, i});
    op(OP_READ);
    u_tlbmo_ahb_master.rd({24'h0, OFS_ENTRY_UPPER}, d);
  endtask : look
  task automatic probe(input logic [18:0] vpn);
    w(OFS_ENTRY_UPPER, {vpn, 5'h0, 8'h5A});
    op(OP_PROBE);
    u_tlbmo_ahb_master.rd({24'h0, OFS_INDEX}, d);
  endtask : probe
  task conclude;
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // hang guard, well above the thousand or so cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      conclude();
    end
  end

  // main sequence
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    ce = 1'b1;
    errors = 0;
    checked = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    expect_reg(OFS_CONFIG, RST_CONFIG);
    expect_reg(OFS_CONFIG_FOUR, RST_CONFIG_FOUR);
    w(8'h40, 32'hFFFF_FFFF);
    expect_reg(8'h40, 32'h0);
    expect_reg(OFS_COMMAND, 32'h0);
    put(4'd5, 19'h12345, 1'b1, 1'b0, 16'h0);
    readback(4'd5, 19'h12345, 1'b0, 16'h0);
    put(4'd6, 19'h0F0FF, 1'b1, 1'b1, 16'h0003);
    readback(4'd6, 19'h0F0FF, 1'b1, 16'h0003);
    probe(19'h12345);
    `CHK(d, 32'h5)
    probe(19'h55555);
    `CHK(d[MISS_POS], 1'b1)
    put(4'd7, 19'h12345, 1'b0, 1'b0, 16'h0);
    expect_reg(OFS_STATUS, 32'h4);
    probe(19'h12345);
    `CHK(d, 32'h5)
    w(OFS_INDEX, 32'h5);
    w(OFS_ENTRY_UPPER, 32'h400);
    op(OP_WRITE);
    expect_reg(OFS_STATUS, 32'h0);
    w(OFS_PAGE_MASK, 32'h1FFF_E000);
    op(OP_READ);
    expect_reg(OFS_ENTRY_UPPER, 32'h400);
    expect_reg(OFS_LOWER_EVEN, 32'h0);
    expect_reg(OFS_LOWER_ODD, 32'h0);
    expect_reg(OFS_PAGE_MASK, 32'h0);
    probe(19'h12345);
    `CHK(d[MISS_POS], 1'b1)
    put(4'd5, 19'h12345, 1'b0, 1'b0, 16'h0);
    probe(19'h12345);
    `CHK(d, 32'h5)
    for (int k = 0; k < 8; k++)
    begin
      w(OFS_CONFIG_FOUR, fc4[k]);
      w(OFS_CONFIG, fcfg[k]);
      for (int j = 0; j < fn[k]; j++) put(pos[j], {15'h008, pos[j]}, j == 0, j == 0, 16'h0);
      w(OFS_INDEX, {28'h0, fidx[k]});
      op(OP_FLUSH);
      for (int j = 0; j < fn[k]; j++)
      begin
        look(pos[j]);
        `CHK(d[ENTRY_INVALID_POS], fexp[k][j])
      end
    end
    w(OFS_CONFIG_FOUR, RST_CONFIG_FOUR);
    w(OFS_CONFIG, RST_CONFIG);
    put(4'd3, 19'h00333, 1'b0, 1'b0, 16'h0);
    for (int k = 0; k < 4; k++)
    begin
      w(OFS_CONFIG, rcfg[k]);
      for (int o = 1; o < 5; o++)
      begin
        w(OFS_COMMAND, o);
        expect_reg(OFS_STATUS, rexp[k]);
      end
    end
    w(OFS_CONFIG, RST_CONFIG);
    look(4'd3);
    `CHK(d[ENTRY_INVALID_POS], 1'b0)
    expect_reg(OFS_STATUS, 32'h0);
    w(OFS_COMMAND, 32'h0);
    w(OFS_COMMAND, 32'h7);
    ce <= 1'b0;
    w(OFS_INDEX, 32'h9);
    ce <= 1'b1;
    expect_reg(OFS_INDEX, 32'h3);
    conclude();
  end
endmodule : tlbmo_tb_top
